// *** ivw_core_model.sv ***
// Purpose: core stand-in that takes offered vectors
// Assumes: ack is sampled on the rising edge
// Notes: slow lets a vector stand one extra cycle
`default_nettype none
module ivw_core_model (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic slow,
   input wire logic vec_valid,
   output var logic vec_ack = 1'h0
);
   logic wait_reg = 1'h0;
   always @(posedge clock) begin
      // held clear in reset so a slow take starts from a known phase
      wait_reg <= vec_valid & ~wait_reg & ~vec_ack & ~sys_rst;
      vec_ack <= vec_valid & ~vec_ack & ~sys_rst & (~slow | wait_reg);
   end
endmodule // ivw_core_model
`default_nettype wire

// *** ivw_defines.vh ***
// Purpose: constants for the interrupt vector and wakeup map
// Assumes: 24-bit program addresses, 20 numbered request lines
// Notes: vectors are fixed; no software-visible registers
`ifndef IVW_DEFINES_VH
`define IVW_DEFINES_VH
`define IVW_NUM_IRQ 20
`define IVW_ADDR_W 24
`define IVW_VEC_RESET 24'h008000
`define IVW_VEC_TRAP 24'h008004
`define IVW_VEC_BASE 24'h008008
`define IVW_VEC_STEP 24'h000004
// wake-capable masks per low-power mode, bit n = irq n
`define IVW_WAKE_HALT_MASK 20'h804F8
`define IVW_WAKE_AHALT_MASK 20'h804FA
`define IVW_RESERVED_MASK 20'h60300
`define IVW_PORT_A_IRQ 3
`define IVW_MODE_RUN 3'h1
`define IVW_MODE_HALT 3'h2
`define IVW_MODE_AHALT 3'h4
`endif

// *** ivw_prio_enc.v ***
// Purpose: lowest-number-first encoder over the request lines
// Assumes: purely combinational
// Notes: lower irq number wins
`include "ivw_defines.vh"
`default_nettype none
module ivw_prio_enc (
   input wire [`IVW_NUM_IRQ-1:0] req,
   output reg found,
   output reg [4:0] idx
);
   integer i;
   always @* begin
      found = 1'b0;
      idx = 5'h00;
      for (i = `IVW_NUM_IRQ-1; i >= 0; i = i - 1) begin
         if (req[i]) begin
            found = 1'b1;
            idx = i[4:0];
         end
      end
   end
endmodule // ivw_prio_enc
`default_nettype wire

// *** ivw_vector_map.v ***
// Purpose: map interrupt sources to vectors and decide wakeup from halt modes
// Assumes: requests are levels synchronous to clock; core takes vector on ack
// Notes: lowest-number priority, reserved-line masking and port A wake qualification are applied here besides enables
`include "ivw_defines.vh"
`default_nettype none
module ivw_vector_map (
   input wire clock,
   input wire sys_rst,
   input wire clk_en,
   input wire trap_req,
   input wire top_level_ext_irq,
   input wire auto_wakeup_irq,
   input wire clk_ctrl_irq,
   input wire port_a_pin_irq,
   input wire port_a_wake_qual,
   input wire port_b_pin_irq,
   input wire port_c_pin_irq,
   input wire port_d_pin_irq,
   input wire port_e_pin_irq,
   input wire spi_eot_irq,
   input wire advanced_timer_upd_irq,
   input wire advanced_timer_trg_irq,
   input wire advanced_timer_brk_irq,
   input wire advanced_timer_cc_irq,
   input wire gp_timer_a_upd_irq,
   input wire gp_timer_a_cc_irq,
   input wire gp_timer_b_upd_irq,
   input wire gp_timer_b_cc_irq,
   input wire i2c_irq,
   input wire [`IVW_NUM_IRQ-1:0] irq_enable,
   input wire halt_enter,
   input wire ahalt_enter,
   input wire vec_ack,
   output reg vec_valid,
   output reg [`IVW_ADDR_W-1:0] vec_addr,
   output reg [4:0] vec_irq,
   output reg vec_is_trap,
   output reg clocks_run,
   output reg halted,
   output reg active_halted
);
   // ****************************************************
   // request vector assembly
   // ****************************************************
   wire [`IVW_NUM_IRQ-1:0] raw_req;
   assign raw_req[0] = top_level_ext_irq;
   assign raw_req[1] = auto_wakeup_irq;
   assign raw_req[2] = clk_ctrl_irq;
   assign raw_req[3] = port_a_pin_irq;
   assign raw_req[4] = port_b_pin_irq;
   assign raw_req[5] = port_c_pin_irq;
   assign raw_req[6] = port_d_pin_irq;
   assign raw_req[7] = port_e_pin_irq;
   assign raw_req[8] = 1'b0;
   assign raw_req[9] = 1'b0;
   assign raw_req[10] = spi_eot_irq;
   // one line carries all non-capture advanced timer events
   assign raw_req[11] = advanced_timer_upd_irq | advanced_timer_trg_irq | advanced_timer_brk_irq;
   assign raw_req[12] = advanced_timer_cc_irq;
   assign raw_req[13] = gp_timer_a_upd_irq;
   assign raw_req[14] = gp_timer_a_cc_irq;
   assign raw_req[15] = gp_timer_b_upd_irq;
   assign raw_req[16] = gp_timer_b_cc_irq;
   assign raw_req[17] = 1'b0;
   assign raw_req[18] = 1'b0;
   assign raw_req[19] = i2c_irq;

   wire [`IVW_NUM_IRQ-1:0] act_req = raw_req & irq_enable & ~(`IVW_RESERVED_MASK);

   // ****************************************************
   // wakeup qualification
   // ****************************************************
   wire [`IVW_NUM_IRQ-1:0] qual_mask;
   genvar g;
   generate
      for (g = 0; g < `IVW_NUM_IRQ; g = g + 1) begin : g_qual
         if (g == `IVW_PORT_A_IRQ) begin : g_pa
            assign qual_mask[g] = port_a_wake_qual;
         end else begin : g_other
            assign qual_mask[g] = 1'b1;
         end
      end
   endgenerate

   wire [`IVW_NUM_IRQ-1:0] wake_halt = act_req & `IVW_WAKE_HALT_MASK & qual_mask;
   wire [`IVW_NUM_IRQ-1:0] wake_ahalt = act_req & `IVW_WAKE_AHALT_MASK & qual_mask;

   wire pick_found;
   wire [4:0] pick_idx;
   ivw_prio_enc u_enc (
      .req(act_req),
      .found(pick_found),
      .idx(pick_idx)
   );

   localparam [2:0] ST_RUN = `IVW_MODE_RUN;
   localparam [2:0] ST_HALT = `IVW_MODE_HALT;
   localparam [2:0] ST_AHALT = `IVW_MODE_AHALT;

   reg [2:0] state_reg;
   reg [2:0] state_next;

   // ****************************************************
   // wake source selection
   // ****************************************************
   // on a wake edge the source that ended the low-power mode is handed
   // over; a lower pending line that may not wake would otherwise win
   wire [`IVW_NUM_IRQ-1:0] wake_now;
   wire wake_found;
   wire [4:0] wake_idx;
   wire [4:0] grant_idx;
   assign wake_now = (state_reg == ST_HALT) ? wake_halt :
                     ((state_reg == ST_AHALT) ? wake_ahalt : {`IVW_NUM_IRQ{1'b0}});
   ivw_prio_enc u_wake_enc (
      .req(wake_now),
      .found(wake_found),
      .idx(wake_idx)
   );
   // in run the plain lowest-number winner applies
   assign grant_idx = wake_found ? wake_idx : pick_idx;

   // vector = base + 4 * irq
   wire [`IVW_ADDR_W-1:0] irq_vec = `IVW_VEC_BASE + {17'h00000, grant_idx, 2'b00};

   // ****************************************************
   // mode state machine
   // ****************************************************
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (halt_enter) begin
               state_next = ST_HALT;
            end else if (ahalt_enter) begin
               state_next = ST_AHALT;
            end
         end
         ST_HALT: begin
            if (|wake_halt) begin
               state_next = ST_RUN;
            end
         end
         ST_AHALT: begin
            if (|wake_ahalt) begin
               state_next = ST_RUN;
            end
         end
         default: state_next = ST_RUN;
      endcase
   end

   wire in_run = (state_reg == ST_RUN);

   // ****************************************************
   // mode registers
   // ****************************************************
   // flags come from the next state, so each output is a flip-flop
   // that changes on the same edge as the mode itself
   always @(posedge clock) begin
      if (sys_rst) begin
         // reset leaves either halt mode whatever clk_en does
         state_reg <= ST_RUN;
         clocks_run <= 1'b1;
         halted <= 1'b0;
         active_halted <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         clocks_run <= (state_next == ST_RUN);
         halted <= (state_next == ST_HALT);
         active_halted <= (state_next == ST_AHALT);
      end
   end

   // ****************************************************
   // vector offer to the core
   // ****************************************************
   // one vector at a time: a new request waits until the core has
   // taken the current one, which costs one idle cycle per hand-over
   always @(posedge clock) begin
      if (sys_rst) begin
         // reset fetches from the reset vector
         vec_valid <= 1'b1;
         vec_addr <= `IVW_VEC_RESET;
         vec_irq <= 5'h00;
         vec_is_trap <= 1'b0;
      end else if (clk_en) begin
         if (vec_valid) begin
            // offered vector holds until the core takes it
            if (vec_ack) begin
               vec_valid <= 1'b0;
            end
         end else if (in_run && trap_req) begin
            // trap wins over irqs; it only arises from executing code
            vec_valid <= 1'b1;
            vec_addr <= `IVW_VEC_TRAP;
            vec_irq <= 5'h00;
            vec_is_trap <= 1'b1;
         end else if (pick_found && state_next == ST_RUN) begin
            // staying in run, or waking this cycle: hand over vector of winner
            vec_valid <= 1'b1;
            vec_addr <= irq_vec;
            vec_irq <= grant_idx;
            vec_is_trap <= 1'b0;
         end
      end
   end
endmodule // ivw_vector_map
`default_nettype wire

// *** ivw_vector_map_assertions.sv ***
// Purpose: port checks for the vector map
// Assumes: one clock, sync reset
// Notes: wake checks expect one source at a time
`default_nettype none
module ivw_vector_map_chk (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic vec_ack,
   input wire logic vec_valid,
   input wire logic vec_is_trap,
   input wire logic clocks_run,
   input wire logic halted,
   input wire logic active_halted,
   input wire logic halt_enter,
   input wire logic auto_wakeup_irq,
   input wire logic spi_eot_irq,
   input wire logic i2c_irq,
   input wire logic [23:0] vec_addr,
   input wire logic [4:0] vec_irq,
   input wire logic [19:0] irq_enable
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_rst; disable iff (1'h0) sys_rst |=> vec_valid && vec_addr == 24'h008000 && clocks_run; endproperty
   a_rst: assert property (p_rst) else $error("reset");
   property p_vec; vec_valid && !vec_is_trap |-> (vec_addr == 24'h008008 + {vec_irq, 2'h0}) ||
      (vec_irq == 5'h0 && vec_addr == 24'h008000); endproperty
   a_vec: assert property (p_vec) else $error("slot");
   property p_trap; vec_valid && vec_is_trap |-> vec_addr == 24'h008004; endproperty
   a_trap: assert property (p_trap) else $error("trap");
   property p_hold; vec_valid && !(vec_ack && clk_en) |=> vec_valid && $stable(vec_addr); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_halt; clocks_run && !vec_valid && clk_en && halt_enter |=> halted && !clocks_run; endproperty
   a_halt: assert property (p_halt) else $error("halt");
   property p_spi; halted && clk_en && spi_eot_irq && irq_enable[10] |=> clocks_run && vec_valid; endproperty
   a_spi: assert property (p_spi) else $error("spi");
   property p_awu; active_halted && clk_en && !vec_valid && auto_wakeup_irq && irq_enable[1] |=> vec_irq == 5'h1;
   endproperty
   a_awu: assert property (p_awu) else $error("awu");
   property p_i2c; active_halted && clk_en && i2c_irq && irq_enable[19] |=> clocks_run; endproperty
   a_i2c: assert property (p_i2c) else $error("i2c");
   c_trap: cover property (vec_valid && vec_is_trap);
   c_wake: cover property ($fell(halted));
   c_awake: cover property ($fell(active_halted));
endmodule // ivw_vector_map_chk
bind ivw_vector_map ivw_vector_map_chk u_chk (.*);
`default_nettype wire

// *** ivw_vector_map_tb.sv ***
// Purpose: self-checking bench for the vector map
// Assumes: core model acks each vector
// Notes: lanes 8 and 9 drive merged timer events
`default_nettype none
module ivw_vector_map_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, trap_req = 1'h0, port_a_wake_qual = 1'h0;
   logic halt_enter = 1'h0, ahalt_enter = 1'h0, slow = 1'h0;
   logic [19:0] rq = 20'h0, irq_enable = 20'hFFFFF;
   wire vec_ack, vec_valid, vec_is_trap, clocks_run, halted, active_halted;
   wire [23:0] vec_addr;
   wire [4:0] vec_irq;
   wire top_level_ext_irq = rq[0], auto_wakeup_irq = rq[1], clk_ctrl_irq = rq[2], port_a_pin_irq = rq[3];
   wire port_b_pin_irq = rq[4], port_c_pin_irq = rq[5], port_d_pin_irq = rq[6], port_e_pin_irq = rq[7];
   wire advanced_timer_trg_irq = rq[8], advanced_timer_brk_irq = rq[9], spi_eot_irq = rq[10];
   wire advanced_timer_upd_irq = rq[11], advanced_timer_cc_irq = rq[12], gp_timer_a_upd_irq = rq[13];
   wire gp_timer_a_cc_irq = rq[14], gp_timer_b_upd_irq = rq[15], gp_timer_b_cc_irq = rq[16], i2c_irq = rq[19];
   int errors = 0, total_checks = 0;
   ivw_vector_map DUT (.*);
   ivw_core_model u_core (.*);
   initial forever #10 clock = ~clock;
   task automatic chk(input logic [24:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wt(input logic lvl);
      for (int n = 0; n < 40 && vec_valid !== lvl; n++)
         @(negedge clock);
   endtask
   task automatic rst();
      sys_rst = 1'h1;
      repeat (2) @(negedge clock);
      sys_rst = 1'h0;
      @(negedge clock);
      chk(vec_addr, 24'h008000);
      chk({22'h0, halted, active_halted}, 24'h0);
      wt(1'h0);
   endtask
   task automatic t_map();
      int k;
      for (int i = 0; i < 17; i++) begin
         k = (i == 8 || i == 9) ? 11 : i;
         rq = 20'h1 << i;
         wt(1'h1);
         chk(vec_addr, 24'h008008 + 24'(4 * k));
         chk({19'h0, vec_irq}, 24'(k));
         rq = 20'h0;
         @(negedge clock);
         wt(1'h0);
      end
      slow = 1'h1;
      trap_req = 1'h1;
      rq = 20'h80000;
      wt(1'h1);
      chk({vec_is_trap, vec_addr}, 25'h1008004);
      trap_req = 1'h0;
      wt(1'h0);
      wt(1'h1);
      chk(vec_addr, 24'h008054);
      rq = 20'h0;
      @(negedge clock);
      wt(1'h0);
      $display("map and trap done");
   endtask
   task automatic t_gate();
      irq_enable = 20'hFFFEF;
      rq = 20'h00010;
      repeat (3) @(negedge clock);
      chk({23'h0, vec_valid}, 24'h0);
      irq_enable = 20'hFFFFF;
      clk_en = 1'h0;
      repeat (3) @(negedge clock);
      chk({23'h0, vec_valid}, 24'h0);
      clk_en = 1'h1;
      wt(1'h1);
      chk(vec_addr, 24'h008018);
      rq = 20'h0;
      @(negedge clock);
      wt(1'h0);
      $display("gate done");
   endtask
   task automatic t_wake();
      logic [19:0] m;
      slow = 1'h0;
      for (int h = 0; h < 2; h++) begin
         port_a_wake_qual = (h == 0);
         m = h ? 20'h804F2 : 20'h804F8;
         for (int i = 0; i < 20; i++) begin
            halt_enter = (h == 0);
            ahalt_enter = (h == 1);
            @(negedge clock);
            halt_enter = 1'h0;
            ahalt_enter = 1'h0;
            rq = 20'h1 << i;
            repeat (3) @(negedge clock);
            chk({23'h0, clocks_run}, {23'h0, m[i]});
            chk({22'h0, halted, active_halted}, m[i] ? 24'h0 : (h ? 24'h1 : 24'h2));
            if (m[i])
               chk(vec_addr, 24'h008008 + 24'(4 * i));
            rq = 20'h0;
            rst();
         end
      end
      $display("wake done");
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100us;
      errors++;
      end_sim();
   end
   initial begin
      repeat (10) @(negedge clock);
      rst();
      t_map();
      t_gate();
      t_wake();
      end_sim();
   end
endmodule // ivw_vector_map_tb
`default_nettype wire
